// ### core/addr_gen_pkg.sv
// Package for the operand address generator: modes, widths, constants, carriers.
// Assumes a single 100 MHz CPU clock domain.
package addr_gen_pkg;

	localparam int ADDR_W = 16;
	localparam int DATA_W = 8;

	// Addressing modes presented by the opcode decoder
	typedef enum logic [4:0] {
		MODE_INHERENT      = 5'h00,
		MODE_IMMEDIATE     = 5'h01,
		MODE_DIR_SHORT     = 5'h02,
		MODE_DIR_LONG      = 5'h03,
		MODE_IDX_NONE      = 5'h04,
		MODE_IDX_SHORT     = 5'h05,
		MODE_IDX_LONG      = 5'h06,
		MODE_IND_SHORT     = 5'h07,
		MODE_IND_LONG      = 5'h08,
		MODE_INDIDX_SHORT  = 5'h09,
		MODE_INDIDX_LONG   = 5'h0A,
		MODE_REL_DIRECT    = 5'h0B,
		MODE_REL_INDIRECT  = 5'h0C,
		MODE_BIT_DIRECT    = 5'h0D,
		MODE_BIT_INDIRECT  = 5'h0E,
		MODE_BITREL_DIRECT = 5'h0F,
		MODE_BITREL_IND    = 5'h10
	} mode_type;

	// Inherent control operations
	typedef enum logic [2:0] {
		CTRL_NONE                   = 3'h0,
		CTRL_SET_IRQ_MASK_OP        = 3'h1,
		CTRL_CLEAR_IRQ_MASK_OP      = 3'h2,
		CTRL_WAIT_FOR_IRQ_OP        = 3'h3,
		CTRL_HALT_OP                = 3'h4,
		CTRL_STACK_POINTER_REINIT_OP = 3'h5
	} ctrl_type;

	typedef enum logic [2:0] {
		ST_IDLE    = 3'h0,
		ST_OPND0   = 3'h1,
		ST_OPND1   = 3'h2,
		ST_PTR0    = 3'h3,
		ST_PTR1    = 3'h4,
		ST_ACCESS  = 3'h5,
		ST_DONE    = 3'h6
	} state_type;

	localparam logic [1:0] IRQ_LEVEL_HIGH = 2'h3;
	localparam logic [1:0] IRQ_LEVEL_LOW  = 2'h0;
	localparam logic [7:0] PAGE_ZERO_HI   = 8'h00;
	localparam logic [15:0] PC_STEP       = 16'h0001;
	localparam logic [15:0] ADDR_ZERO     = 16'h0000;

	// Decoded instruction presented with the opcode
	typedef struct packed {
		mode_type   mode;
		ctrl_type   ctrl;
		logic       useSecondary;
		logic       rmw;
	} decode_type;

	// Result handed to the execution unit
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0]  immValue;
		logic        isImmediate;
		logic        isAccess;
		logic        modeError;
	} result_type;

endpackage

// ### core/cpu_operand_address_generator.sv
// Operand address generator: fetches operand/pointer bytes after an opcode and forms
// the effective address for all seventeen addressing modes.
// Assumes a memory bus answering each read with rdValid one or more cycles later.
//
// Function
// - Seventeen addressing modes in seven groups are supported.
// - Short forms without indexing confine the operand address to page zero 0x00-0xFF.
// - Long forms reach any address in 64 Kbyte.
// - Read-modify-write instructions accept short forms only.
// - Inherent instructions are one byte, no operand bytes fetched.
// - Immediate instructions carry their operand value in the second byte.
// - Short direct uses one following byte as address 0x00-0xFF.
// - Long direct uses a 16-bit address from two following bytes.
// - Indexed address is unsigned sum of chosen index and offset.
// - Indexed no-offset fetches no byte, uses index value alone.
// - Short indexed adds byte offset untruncated, range 0x000-0x1FE.
// - Long indexed adds index to 16-bit offset from two bytes.
// - Indirect modes read the operand address from a memory pointer.
// - Short indirect fetches a byte pointer from page zero.
// - Long indirect fetches a word pointer from page zero.
// - Indirect indexed adds index register to a memory pointer.
// - Short indirect indexed: byte pointer plus index, range 0x000-0x1FE.
// - Mask-set raises interrupt mask to 3, mask-clear lowers to 0.
// - Halt stops oscillator; wait-for-interrupt enters low power till interrupt.
// - Relative modes add signed 8-bit displacement to program counter; the bit-relative modes form no branch target.
// - Long indirect indexed: word pointer from page zero plus index.
`timescale 1ns/1ps
`default_nettype none

module cpu_operand_address_generator
(
	// Clock and reset
	input  wire logic                      clk,
	input  wire logic                      rst_b,
	input  wire logic                      clkEn,
	// Opcode issue
	input  wire logic                      opStart,
	input  wire addr_gen_pkg::decode_type  opDecode,
	input  wire logic [15:0]               opPc,
	input  wire logic [7:0]                indexPrimary,
	input  wire logic [7:0]                indexSecondary,
	input  wire logic                      irqPending,
	// Memory bus
	output logic                           rdReq,
	output logic [15:0]                    rdAddr,
	input  wire logic                      rdValid,
	input  wire logic [7:0]                rdData,
	// Results
	output logic                           busy,
	output logic                           resultValid,
	output addr_gen_pkg::result_type       result,
	output logic                           branchValid,
	output logic [15:0]                    branchTarget,
	output logic [1:0]                     irqMask,
	output logic                           haltOsc,
	output logic                           lowPowerWait,
	output logic                           spReinit
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	addr_gen_pkg::state_type   state_ff, nxt_state;
	addr_gen_pkg::decode_type  dec_ff, nxt_dec;
	logic [15:0]               pc_ff, nxt_pc;
	logic [15:0]               val_ff, nxt_val;
	logic [7:0]                index_ff, nxt_index;
	logic                      rdReq_ff, nxt_rdReq;
	logic [15:0]               rdAddr_ff, nxt_rdAddr;
	logic                      resValid_ff, nxt_resValid;
	addr_gen_pkg::result_type  result_ff, nxt_result;
	logic                      brValid_ff, nxt_brValid;
	logic [15:0]               brTarget_ff, nxt_brTarget;
	logic [1:0]                irqMask_ff, nxt_irqMask;
	logic                      halt_ff, nxt_halt;
	logic                      wait_ff, nxt_wait;
	logic                      spReinit_ff, nxt_spReinit;
	logic                      busy_ff, nxt_busy;

	logic [1:0]                opndCount;
	logic [4:0]                modeFlags;
	logic                      hasPtr;
	logic                      ptrWord;
	logic                      indexed;
	logic                      relative;
	logic                      longForm;

	// ------------------------------------------------------------
	// Mode properties
	// ------------------------------------------------------------
	// Flag order: pointer, word pointer, indexed, relative, long form
	assign {hasPtr, ptrWord, indexed, relative, longForm} = modeFlags;

	// Operand byte count and mode flags per mode
	always_comb
	begin
		{opndCount, modeFlags} = {2'h0, 5'h00};
		unique case (dec_ff.mode)
			addr_gen_pkg::MODE_INHERENT:      {opndCount, modeFlags} = {2'h0, 5'h00};
			addr_gen_pkg::MODE_IMMEDIATE:     {opndCount, modeFlags} = {2'h1, 5'h00};
			addr_gen_pkg::MODE_DIR_SHORT:     {opndCount, modeFlags} = {2'h1, 5'h00};
			addr_gen_pkg::MODE_DIR_LONG:      {opndCount, modeFlags} = {2'h2, 5'h01};
			addr_gen_pkg::MODE_IDX_NONE:      {opndCount, modeFlags} = {2'h0, 5'h04};
			addr_gen_pkg::MODE_IDX_SHORT:     {opndCount, modeFlags} = {2'h1, 5'h04};
			addr_gen_pkg::MODE_IDX_LONG:      {opndCount, modeFlags} = {2'h2, 5'h05};
			addr_gen_pkg::MODE_IND_SHORT:     {opndCount, modeFlags} = {2'h1, 5'h10};
			addr_gen_pkg::MODE_IND_LONG:      {opndCount, modeFlags} = {2'h1, 5'h19};
			addr_gen_pkg::MODE_INDIDX_SHORT:  {opndCount, modeFlags} = {2'h1, 5'h14};
			addr_gen_pkg::MODE_INDIDX_LONG:   {opndCount, modeFlags} = {2'h1, 5'h1D};
			addr_gen_pkg::MODE_REL_DIRECT:    {opndCount, modeFlags} = {2'h1, 5'h02};
			addr_gen_pkg::MODE_REL_INDIRECT:  {opndCount, modeFlags} = {2'h1, 5'h12};
			addr_gen_pkg::MODE_BIT_DIRECT:    {opndCount, modeFlags} = {2'h1, 5'h00};
			addr_gen_pkg::MODE_BIT_INDIRECT:  {opndCount, modeFlags} = {2'h1, 5'h10};
			addr_gen_pkg::MODE_BITREL_DIRECT: {opndCount, modeFlags} = {2'h1, 5'h00};
			addr_gen_pkg::MODE_BITREL_IND:    {opndCount, modeFlags} = {2'h1, 5'h10};
			default:                          {opndCount, modeFlags} = {2'h0, 5'h00};
		endcase
	end

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	// Next-state and datapath for byte fetches and address formation
	always_comb
	begin
		nxt_state    = state_ff;
		nxt_dec      = dec_ff;
		nxt_pc       = pc_ff;
		nxt_val      = val_ff;
		nxt_index    = index_ff;
		nxt_rdReq    = 1'b0;
		nxt_rdAddr   = rdAddr_ff;
		nxt_resValid = 1'b0;
		nxt_result   = result_ff;
		nxt_brValid  = 1'b0;
		nxt_brTarget = brTarget_ff;
		nxt_irqMask  = irqMask_ff;
		nxt_halt     = halt_ff;
		nxt_wait     = wait_ff && !irqPending;
		nxt_spReinit = 1'b0;
		unique case (state_ff)
			addr_gen_pkg::ST_IDLE:
			begin
				if (opStart && !halt_ff)
				begin
					nxt_dec   = opDecode;
					nxt_pc    = opPc + addr_gen_pkg::PC_STEP;
					nxt_val   = addr_gen_pkg::ADDR_ZERO;
					nxt_index = opDecode.useSecondary ? indexSecondary : indexPrimary;
					nxt_state = addr_gen_pkg::ST_OPND0;
					unique case (opDecode.ctrl)
						addr_gen_pkg::CTRL_SET_IRQ_MASK_OP:   nxt_irqMask = addr_gen_pkg::IRQ_LEVEL_HIGH;
						addr_gen_pkg::CTRL_CLEAR_IRQ_MASK_OP: nxt_irqMask = addr_gen_pkg::IRQ_LEVEL_LOW;
						addr_gen_pkg::CTRL_WAIT_FOR_IRQ_OP:   nxt_wait = 1'b1;
						addr_gen_pkg::CTRL_HALT_OP:           nxt_halt = 1'b1;
						addr_gen_pkg::CTRL_STACK_POINTER_REINIT_OP: nxt_spReinit = 1'b1;
						default:                              nxt_halt = halt_ff;
					endcase
				end
				else if (halt_ff && irqPending)
				begin
					nxt_halt = 1'b0;
				end
			end
			addr_gen_pkg::ST_OPND0:
			begin
				// Fetch first operand byte or finish at once
				if (dec_ff.rmw && longForm)
				begin
					nxt_result.modeError   = 1'b1;
					nxt_result.isAccess    = 1'b0;
					nxt_result.isImmediate = 1'b0;
					nxt_resValid = 1'b1;
					nxt_state    = addr_gen_pkg::ST_DONE;
				end
				else if (opndCount == 2'h0)
				begin
					nxt_state = addr_gen_pkg::ST_ACCESS;
				end
				else if (!rdReq_ff)
				begin
					nxt_rdReq  = 1'b1;
					nxt_rdAddr = pc_ff;
				end
				else if (rdValid)
				begin
					nxt_val   = {8'h00, rdData};
					nxt_pc    = pc_ff + addr_gen_pkg::PC_STEP;
					nxt_state = (opndCount == 2'h2) ? addr_gen_pkg::ST_OPND1
						: (hasPtr ? addr_gen_pkg::ST_PTR0 : addr_gen_pkg::ST_ACCESS);
				end
				else
				begin
					nxt_rdReq = 1'b1;
				end
			end
			addr_gen_pkg::ST_OPND1:
			begin
				if (!rdReq_ff)
				begin
					nxt_rdReq  = 1'b1;
					nxt_rdAddr = pc_ff;
				end
				else if (rdValid)
				begin
					nxt_val   = {val_ff[7:0], rdData};
					nxt_pc    = pc_ff + addr_gen_pkg::PC_STEP;
					nxt_state = addr_gen_pkg::ST_ACCESS;
				end
				else
				begin
					nxt_rdReq = 1'b1;
				end
			end
			addr_gen_pkg::ST_PTR0:
			begin
				// Pointer lies in page zero
				if (!rdReq_ff)
				begin
					nxt_rdReq  = 1'b1;
					nxt_rdAddr = {addr_gen_pkg::PAGE_ZERO_HI, val_ff[7:0]};
				end
				else if (rdValid)
				begin
					nxt_val    = {8'h00, rdData};
					nxt_rdAddr = rdAddr_ff + addr_gen_pkg::PC_STEP;
					nxt_state  = ptrWord ? addr_gen_pkg::ST_PTR1 : addr_gen_pkg::ST_ACCESS;
				end
				else
				begin
					nxt_rdReq = 1'b1;
				end
			end
			addr_gen_pkg::ST_PTR1:
			begin
				nxt_rdReq = 1'b1;
				if (rdReq_ff && rdValid)
				begin
					nxt_rdReq = 1'b0;
					nxt_val   = {val_ff[7:0], rdData};
					nxt_state = addr_gen_pkg::ST_ACCESS;
				end
			end
			addr_gen_pkg::ST_ACCESS:
			begin
				// Form effective address or branch target
				nxt_result.modeError   = 1'b0;
				nxt_result.isImmediate = (dec_ff.mode == addr_gen_pkg::MODE_IMMEDIATE);
				nxt_result.immValue    = val_ff[7:0];
				nxt_result.isAccess    = !relative && (dec_ff.mode != addr_gen_pkg::MODE_INHERENT)
					&& (dec_ff.mode != addr_gen_pkg::MODE_IMMEDIATE);
				if (indexed)
					nxt_result.addr = val_ff + {8'h00, index_ff};
				else if (longForm)
					nxt_result.addr = val_ff;
				else
					nxt_result.addr = {addr_gen_pkg::PAGE_ZERO_HI, val_ff[7:0]};
				if (relative)
				begin
					nxt_brTarget = pc_ff + {{8{val_ff[7]}}, val_ff[7:0]};
					nxt_brValid  = 1'b1;
				end
				nxt_resValid = 1'b1;
				nxt_state    = addr_gen_pkg::ST_DONE;
			end
			addr_gen_pkg::ST_DONE:    nxt_state = addr_gen_pkg::ST_IDLE;
			default:                  nxt_state = addr_gen_pkg::ST_IDLE;
		endcase
		nxt_busy = (nxt_state != addr_gen_pkg::ST_IDLE); // Registered so busy leaves a flip-flop
	end

	// Register all state
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			state_ff    <= addr_gen_pkg::ST_IDLE;
			dec_ff      <= '0;
			pc_ff       <= addr_gen_pkg::ADDR_ZERO;
			val_ff      <= addr_gen_pkg::ADDR_ZERO;
			index_ff    <= 8'h00;
			rdReq_ff    <= 1'b0;
			rdAddr_ff   <= addr_gen_pkg::ADDR_ZERO;
			resValid_ff <= 1'b0;
			result_ff   <= '0;
			brValid_ff  <= 1'b0;
			brTarget_ff <= addr_gen_pkg::ADDR_ZERO;
			irqMask_ff  <= addr_gen_pkg::IRQ_LEVEL_HIGH;
			halt_ff     <= 1'b0;
			wait_ff     <= 1'b0;
			spReinit_ff <= 1'b0;
			busy_ff     <= 1'b0;
		end
		else if (clkEn)
		begin
			state_ff    <= nxt_state;
			dec_ff      <= nxt_dec;
			pc_ff       <= nxt_pc;
			val_ff      <= nxt_val;
			index_ff    <= nxt_index;
			rdReq_ff    <= nxt_rdReq;
			rdAddr_ff   <= nxt_rdAddr;
			resValid_ff <= nxt_resValid;
			result_ff   <= nxt_result;
			brValid_ff  <= nxt_brValid;
			brTarget_ff <= nxt_brTarget;
			irqMask_ff  <= nxt_irqMask;
			halt_ff     <= nxt_halt;
			wait_ff     <= nxt_wait;
			spReinit_ff <= nxt_spReinit;
			busy_ff     <= nxt_busy;
		end
	end

	// Outputs straight from flip-flops
	assign rdReq        = rdReq_ff;
	assign rdAddr       = rdAddr_ff;
	assign busy         = busy_ff;
	assign resultValid  = resValid_ff;
	assign result       = result_ff;
	assign branchValid  = brValid_ff;
	assign branchTarget = brTarget_ff;
	assign irqMask      = irqMask_ff;
	assign haltOsc      = halt_ff;
	assign lowPowerWait = wait_ff;
	assign spReinit     = spReinit_ff;

endmodule // cpu_operand_address_generator

`default_nettype wire

// ### verif/addr_gen_props.sv
// Checker for the operand address generator.
// Assumes binding onto the generator top module.
`timescale 1ns/1ps
`default_nettype none
module addr_gen_props
(
	// Clock and reset
	input wire logic                      clk,
	input wire logic                      rst_b,
	input wire logic                      clkEn,
	// Issue and bus
	input wire logic                      opStart,
	input wire addr_gen_pkg::decode_type  opDecode,
	input wire logic [15:0]               opPc,
	input wire logic                      rdReq,
	input wire logic [15:0]               rdAddr,
	input wire logic                      rdValid,
	// Results
	input wire logic                      busy,
	input wire logic                      resultValid,
	input wire addr_gen_pkg::result_type  result,
	input wire logic                      branchValid,
	input wire logic [1:0]                irqMask,
	input wire logic                      haltOsc
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	logic        start;
	logic        isLong;
	logic        firstPend_ff;
	logic [15:0] pcHold_ff;

	// Accepted start and long-form decode
	assign start = clkEn && opStart && !busy && !haltOsc;
	assign isLong = opDecode.mode inside {addr_gen_pkg::MODE_DIR_LONG, addr_gen_pkg::MODE_IDX_LONG,
		addr_gen_pkg::MODE_IND_LONG, addr_gen_pkg::MODE_INDIDX_LONG};

	// Tracks the first read after a start
	always_ff @(posedge clk)
	begin
		if (!rst_b)
			firstPend_ff <= 1'b0;
		else if (start)
			firstPend_ff <= 1'b1;
		else if (clkEn && rdReq && rdValid)
			firstPend_ff <= 1'b0;
		if (start)
			pcHold_ff <= opPc;
	end

	mask_reset_a: assert property ($rose(rst_b) |-> irqMask == 2'h3) else $error("mask not 3 after reset");
	rd_hold_a: assert property (rdReq && !rdValid |=> rdReq && $stable(rdAddr)) else $error("read dropped");
	first_read_a: assert property (rdReq && firstPend_ff |-> rdAddr == pcHold_ff + 16'h0001)
		else $error("first read not after opcode");
	inherent_time_a: assert property (start && opDecode.mode == addr_gen_pkg::MODE_INHERENT ##1 clkEn[*2]
		|=> resultValid) else $error("inherent late");
	result_pulse_a: assert property (resultValid && clkEn |=> !resultValid) else $error("result pulse long");
	branch_pair_a: assert property (branchValid |-> resultValid) else $error("branch without result");
	idle_quiet_a: assert property (!busy |-> !rdReq) else $error("read while idle");
	rmw_long_a: assert property (start && opDecode.rmw && isLong |=> !rdReq throughout
		##[0:7] (resultValid && result.modeError)) else $error("long rmw not refused");
	mask_set_a: assert property (start && opDecode.ctrl == addr_gen_pkg::CTRL_SET_IRQ_MASK_OP
		|-> ##[1:6] irqMask == 2'h3) else $error("mask not raised");
	mask_clear_a: assert property (start && opDecode.ctrl == addr_gen_pkg::CTRL_CLEAR_IRQ_MASK_OP
		|-> ##[1:6] irqMask == 2'h0) else $error("mask not lowered");
	halt_hold_a: assert property (haltOsc && !busy |=> !busy) else $error("start taken while halted");

	cover property (resultValid && result.isImmediate);
	cover property (branchValid);
	cover property (resultValid && result.modeError);
endmodule // addr_gen_props
`default_nettype wire

// ### verif/mem_model.sv
// Program and data memory answering byte reads.
// Assumes one read held by rdReq until rdValid.
`timescale 1ns/1ps
`default_nettype none
module mem_model
(
	// Clock and delay
	input wire logic         clk,
	input wire logic [1:0]   lat,
	// Read bus
	input wire logic         rdReq,
	input wire logic [15:0]  rdAddr,
	output logic             rdValid,
	output logic [7:0]       rdData
);
	logic [1:0] waitCnt = 2'h0;

	// Memory contents as a function of address
	function automatic logic [7:0] memByte(input logic [15:0] a);
		return ~a[7:0] ^ a[15:8];
	endfunction

	initial rdValid = 1'b0;
	initial rdData = 8'h00;

	// Answers after lat wait cycles; data churns except while a read is waiting
	always @(posedge clk)
	begin
		if (rdValid)
		begin
			rdValid <= 1'b0;
			rdData <= ~rdData;
			waitCnt <= 2'h0;
		end
		else if (rdReq && waitCnt == lat)
		begin
			rdValid <= 1'b1;
			rdData <= memByte(rdAddr);
		end
		else if (rdReq)
			waitCnt <= waitCnt + 2'h1;
		else
			rdData <= ~rdData;
	end
endmodule // mem_model
`default_nettype wire

// ### verif/testbench.sv
// Testbench for the operand address generator.
// Assumes mem_model as the memory and addr_gen_props bound in.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic                      clk = 1'b0;
	logic                      rst_b = 1'b0;
	logic                      clkEn = 1'b1;
	logic                      opStart = 1'b0;
	addr_gen_pkg::decode_type  opDecode = '0;
	logic [15:0]               opPc = 16'h0000;
	logic [7:0]                ixP = 8'h00;
	logic [7:0]                ixS = 8'h00;
	logic                      irqPending = 1'b0;
	logic [1:0]                lat = 2'h0;
	logic                      rdReq, rdValid, busy, resultValid, branchValid;
	logic                      haltOsc, lowPowerWait, spReinit;
	logic [15:0]               rdAddr, branchTarget;
	logic [7:0]                rdData;
	logic [1:0]                irqMask;
	addr_gen_pkg::result_type  result;
	int                        n_fail = 0;
	int                        check_count = 0;
	int                        nRd = 0;

	always #5 clk = ~clk;

	cpu_operand_address_generator dut (.clk(clk), .rst_b(rst_b), .clkEn(clkEn), .opStart(opStart),
		.opDecode(opDecode), .opPc(opPc), .indexPrimary(ixP), .indexSecondary(ixS),
		.irqPending(irqPending), .rdReq(rdReq), .rdAddr(rdAddr), .rdValid(rdValid), .rdData(rdData),
		.busy(busy), .resultValid(resultValid), .result(result), .branchValid(branchValid),
		.branchTarget(branchTarget), .irqMask(irqMask), .haltOsc(haltOsc), .lowPowerWait(lowPowerWait),
		.spReinit(spReinit));
	mem_model mem (.clk(clk), .lat(lat), .rdReq(rdReq), .rdAddr(rdAddr), .rdValid(rdValid), .rdData(rdData));

	// Counts reads taken by the generator
	always @(posedge clk)
		if (clkEn && rdReq && rdValid)
			nRd <= nRd + 1;

	task automatic end_sim();
		$display("Counts: %0d checks, %0d mismatches", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask

	// One instruction: start, await result, judge address, bytes and side effects
	task automatic run_op(input addr_gen_pkg::mode_type md, input addr_gen_pkg::ctrl_type ct,
		input logic sec, input logic rmw, input logic [15:0] pc, input logic frz);
		logic [7:0]  ix, b1, p;
		logic [15:0] ea, w, tgt;
		int          n, k, base;
		logic        sp;
		logic        acc;
		ix = sec ? ~pc[15:8] : pc[15:8];
		b1 = mem.memByte(pc + 16'h0001);
		p = mem.memByte({8'h00, b1});
		w = {p, mem.memByte({8'h00, b1} + 16'h0001)};
		tgt = 16'h0000;
		ea = {8'h00, b1};
		n = 1;
		case (md)
			addr_gen_pkg::MODE_INHERENT: n = 0;
			addr_gen_pkg::MODE_DIR_LONG: {ea, n} = {b1, mem.memByte(pc + 16'h0002), 32'd2};
			addr_gen_pkg::MODE_IDX_NONE: {ea, n} = {8'h00, ix, 32'd0};
			addr_gen_pkg::MODE_IDX_SHORT: ea = {8'h00, b1} + {8'h00, ix};
			addr_gen_pkg::MODE_IDX_LONG: {ea, n} = {{b1, mem.memByte(pc + 16'h0002)} + {8'h00, ix}, 32'd2};
			addr_gen_pkg::MODE_IND_SHORT, addr_gen_pkg::MODE_BIT_INDIRECT: {ea, n} = {8'h00, p, 32'd2};
			addr_gen_pkg::MODE_IND_LONG: {ea, n} = {w, 32'd3};
			addr_gen_pkg::MODE_INDIDX_SHORT: {ea, n} = {{8'h00, p} + {8'h00, ix}, 32'd2};
			addr_gen_pkg::MODE_INDIDX_LONG: {ea, n} = {w + {8'h00, ix}, 32'd3};
			addr_gen_pkg::MODE_REL_DIRECT: tgt = pc + 16'h0002 + {{8{b1[7]}}, b1};
			addr_gen_pkg::MODE_REL_INDIRECT: {tgt, n} = {pc + 16'h0002 + {{8{p[7]}}, p}, 32'd2};
			addr_gen_pkg::MODE_BITREL_DIRECT: n = -1;
			addr_gen_pkg::MODE_BITREL_IND: {ea, n} = {8'h00, p, -32'sd1};
			default: n = 1;
		endcase
		if (rmw && md inside {addr_gen_pkg::MODE_DIR_LONG, addr_gen_pkg::MODE_IDX_LONG,
			addr_gen_pkg::MODE_IND_LONG, addr_gen_pkg::MODE_INDIDX_LONG})
			n = 0;
		acc = !(n == 0 && rmw) && !(md inside {addr_gen_pkg::MODE_INHERENT, addr_gen_pkg::MODE_IMMEDIATE,
			addr_gen_pkg::MODE_REL_DIRECT, addr_gen_pkg::MODE_REL_INDIRECT});
		opDecode = '{mode: md, ctrl: ct, useSecondary: sec, rmw: rmw};
		opPc = pc;
		ixP = pc[15:8];
		ixS = ~pc[15:8];
		opStart = 1'b1;
		base = nRd;
		if (frz)
		begin
			clkEn = 1'b0;
			repeat (3) @(posedge clk);
			#1 check(busy, 1'b0);
			clkEn = 1'b1;
		end
		@(posedge clk);
		#1 opStart = 1'b0;
		sp = spReinit;
		for (k = 0; k < 40 && resultValid !== 1'b1; k++)
		begin
			@(posedge clk);
			#1 sp = sp | spReinit;
		end
		if (k == 40)
		begin
			n_fail++;
			end_sim();
		end
		if (n >= 0)
			check(16'(nRd - base), 16'(n));
		check(branchValid, tgt != 16'h0000);
		check(sp, ct == addr_gen_pkg::CTRL_STACK_POINTER_REINIT_OP);
		check({result.isAccess, result.isImmediate}, {acc, md == addr_gen_pkg::MODE_IMMEDIATE});
		if (tgt != 16'h0000)
			check(branchTarget, tgt);
		else if (n == 0 && rmw)
			check(result.modeError, 1'b1);
		else if (md == addr_gen_pkg::MODE_IMMEDIATE)
			check({result.isImmediate, result.immValue}, {1'b1, b1});
		else if (md != addr_gen_pkg::MODE_INHERENT)
			check(result.addr, ea);
		for (k = 0; k < 10 && busy !== 1'b0; k++)
			@(posedge clk) #1;
		if (k == 10)
		begin
			n_fail++;
			end_sim();
		end
	endtask

	// Every mode but inherent, short and long, with boundary sums
	task automatic all_modes();
		for (int m = 1; m <= 16; m++)
		begin
			lat = 2'(m);
			run_op(addr_gen_pkg::mode_type'(m), addr_gen_pkg::CTRL_NONE, m[0], 1'b0, 16'h1230 + 16'(m * 7), 1'b0);
		end
		run_op(addr_gen_pkg::MODE_IDX_SHORT, addr_gen_pkg::CTRL_NONE, 1'b0, 1'b0, 16'hFFFE, 1'b1);
		run_op(addr_gen_pkg::MODE_IND_SHORT, addr_gen_pkg::CTRL_NONE, 1'b0, 1'b1, 16'h00F0, 1'b0);
		run_op(addr_gen_pkg::MODE_DIR_LONG, addr_gen_pkg::CTRL_NONE, 1'b0, 1'b1, 16'h4000, 1'b0);
	endtask

	// Inherent controls, then halt and wait left by a pending interrupt
	task automatic control_ops();
		run_op(addr_gen_pkg::MODE_INHERENT, addr_gen_pkg::CTRL_CLEAR_IRQ_MASK_OP, 1'b0, 1'b0, 16'h0100, 1'b0);
		check(irqMask, 2'h0);
		run_op(addr_gen_pkg::MODE_INHERENT, addr_gen_pkg::CTRL_SET_IRQ_MASK_OP, 1'b0, 1'b0, 16'h0101, 1'b0);
		check(irqMask, 2'h3);
		run_op(addr_gen_pkg::MODE_INHERENT, addr_gen_pkg::CTRL_STACK_POINTER_REINIT_OP, 1'b0, 1'b0, 16'h0102, 1'b0);
		run_op(addr_gen_pkg::MODE_INHERENT, addr_gen_pkg::CTRL_WAIT_FOR_IRQ_OP, 1'b0, 1'b0, 16'h0103, 1'b0);
		check(lowPowerWait, 1'b1);
		irqPending = 1'b1;
		repeat (3) @(posedge clk);
		#1 check(lowPowerWait, 1'b0);
		irqPending = 1'b0;
		run_op(addr_gen_pkg::MODE_INHERENT, addr_gen_pkg::CTRL_HALT_OP, 1'b0, 1'b0, 16'h0104, 1'b0);
		check(haltOsc, 1'b1);
		opStart = 1'b1;
		repeat (4) @(posedge clk);
		#1 check(busy, 1'b0);
		opStart = 1'b0;
		irqPending = 1'b1;
		repeat (3) @(posedge clk);
		#1 check(haltOsc, 1'b0);
		irqPending = 1'b0;
	endtask

	// Reset, then the scenarios
	initial
	begin
		repeat (4) @(posedge clk);
		#1 rst_b = 1'b1;
		check({irqMask, busy, resultValid, rdReq}, {2'h3, 3'h0});
		all_modes();
		control_ops();
		end_sim();
	end
endmodule // testbench

bind cpu_operand_address_generator addr_gen_props props (.clk(clk), .rst_b(rst_b), .clkEn(clkEn),
	.opStart(opStart), .opDecode(opDecode), .opPc(opPc), .rdReq(rdReq), .rdAddr(rdAddr), .rdValid(rdValid),
	.busy(busy), .resultValid(resultValid), .result(result), .branchValid(branchValid), .irqMask(irqMask),
	.haltOsc(haltOsc));
`default_nettype wire
